// [core/pph_top.sv]
// Two handshaking 8-bit peripheral ports behind an APB slave.
//
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/1ps
module pph_top (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [7:0]  port_a_in,
   output logic      [7:0]  port_a_out,
   output logic      [7:0]  port_a_oe,
   input  wire logic [7:0]  port_b_in,
   output logic      [7:0]  port_b_out,
   output logic      [7:0]  port_b_oe,
   input  wire logic        port_a_data_ready_in,
   output logic             port_a_ack_out,
   input  wire logic        port_b_ack_in,
   output logic             port_b_strobe_out,
   output logic             irq_n,
   output logic             irq
);
   import pph_pkg::*;

   // ----------------------------------------------------------------------
   // State.
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [7:0]  data_a;
      logic [7:0]  dir_a;
      logic [7:0]  data_b;
      logic [7:0]  dir_b;
      logic [5:0]  ctrl;
      logic [1:0]  flags;
      logic [1:0]  mask;
      logic        ack_a;
      logic        strobe_b;
      logic [31:0] rdata;
   } pph_state_t;

   pph_state_t s_q;
   pph_state_t s_d;

   logic [7:0] pa_sync;
   logic [7:0] pb_sync;
   logic [1:0] ctl_sync;
   logic       rdy_evt;
   logic       ack_evt;

   // ----------------------------------------------------------------------
   // Pin input synchronisers and edge detectors.
   // ----------------------------------------------------------------------
   pph_sync #(.W(18)) u_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in ({port_b_ack_in, port_a_data_ready_in,
                  port_b_in, port_a_in}),
      .sync_out ({ctl_sync, pb_sync, pa_sync})
   );

   pph_edge u_rdy_edge (
      .pclk       (pclk),
      .presetn    (presetn),
      .level_in   (ctl_sync[0]),
      .rise_sel   (s_q.ctrl[PPH_CTRL_RDY_POS]),
      .edge_pulse (rdy_evt)
   );

   pph_edge u_ack_edge (
      .pclk       (pclk),
      .presetn    (presetn),
      .level_in   (ctl_sync[1]),
      .rise_sel   (s_q.ctrl[PPH_CTRL_ACK_POS]),
      .edge_pulse (ack_evt)
   );

   // ----------------------------------------------------------------------
   // Bus helpers.
   // ----------------------------------------------------------------------
   // A pin reads as the driven value on outputs and the pin on inputs.
   function automatic logic [7:0] pin_mix(input logic [7:0] dat,
                                          input logic [7:0] dir,
                                          input logic [7:0] pin);
      pin_mix = (dat & dir) | (pin & ~dir);
   endfunction

   function automatic logic addr_known(input logic [7:0] a);
      addr_known = (a == PPH_OFF_DATA_A) || (a == PPH_OFF_DIR_A) ||
                   (a == PPH_OFF_DATA_B) || (a == PPH_OFF_DIR_B) ||
                   (a == PPH_OFF_CTRL)   || (a == PPH_OFF_STAT)  ||
                   (a == PPH_OFF_MASK);
   endfunction

   logic acc;
   logic wr;
   logic rd;

   // The slave answers in the first access cycle, so no wait states.
   assign acc     = psel && penable;
   assign wr      = acc && pwrite;
   assign rd      = acc && !pwrite;
   assign pready  = 1'b1;
   assign pslverr = acc && !addr_known(paddr);

   // ----------------------------------------------------------------------
   // Next-state logic.
   // ----------------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      // Writes take effect at the edge that completes the access.
      if (wr) begin
         case (paddr)
            PPH_OFF_DATA_A: s_d.data_a = pwdata[7:0];
            PPH_OFF_DIR_A:  s_d.dir_a  = pwdata[7:0];
            PPH_OFF_DATA_B: s_d.data_b = pwdata[7:0];
            PPH_OFF_DIR_B:  s_d.dir_b  = pwdata[7:0];
            PPH_OFF_CTRL:   s_d.ctrl   = pwdata[5:0];
            PPH_OFF_STAT:   s_d.flags  = s_q.flags & ~pwdata[1:0];
            PPH_OFF_MASK:   s_d.mask   = pwdata[1:0];
            default:        s_d.ctrl   = s_q.ctrl;
         endcase
      end
      // Read data is registered; a flop stage keeps prdata glitch free.
      s_d.rdata = 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
         case (paddr)
            PPH_OFF_DATA_A:
               s_d.rdata[7:0] = pin_mix(s_q.data_a, s_q.dir_a,
                                        pa_sync);
            PPH_OFF_DIR_A:  s_d.rdata[7:0] = s_q.dir_a;
            PPH_OFF_DATA_B:
               s_d.rdata[7:0] = pin_mix(s_q.data_b, s_q.dir_b, pb_sync);
            PPH_OFF_DIR_B:  s_d.rdata[7:0] = s_q.dir_b;
            PPH_OFF_CTRL:   s_d.rdata[5:0] = s_q.ctrl;
            PPH_OFF_STAT:   s_d.rdata[1:0] = s_q.flags;
            PPH_OFF_MASK:   s_d.rdata[1:0] = s_q.mask;
            default:        s_d.rdata      = 32'h0000_0000;
         endcase
      end
      // Reading a data register clears that port's flag.
      if (rd && paddr == PPH_OFF_DATA_A) begin
         s_d.flags[PPH_ST_RDY_A] = 1'b0;
      end
      if (rd && paddr == PPH_OFF_DATA_B) begin
         s_d.flags[PPH_ST_ACK_B] = 1'b0;
      end
      // Port A read handshake: a processor read drops the ack.
      if (rd && paddr == PPH_OFF_DATA_A) begin
         s_d.ack_a = 1'b0;
      end
      // Data-ready edge raises the ack; it wins over a same-cycle read.
      if (rdy_evt) begin
         s_d.ack_a = 1'b1;
      end
      // Port B write handshake: each data write drops the strobe.
      if (wr && paddr == PPH_OFF_DATA_B) begin
         s_d.strobe_b = 1'b0;
      end else if (ack_evt) begin
         s_d.strobe_b = 1'b1;  // Low until the ack acts.
      end
      // Hardware events set flags; the set wins over any clear.
      if (rdy_evt) begin
         s_d.flags[PPH_ST_RDY_A] = 1'b1;
      end
      if (ack_evt) begin
         s_d.flags[PPH_ST_ACK_B] = 1'b1;
      end
   end

   // ----------------------------------------------------------------------
   // State register.
   // ----------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q.data_a   <= PPH_RST_PORT;
         s_q.dir_a    <= PPH_RST_PORT;
         s_q.data_b   <= PPH_RST_PORT;
         s_q.dir_b    <= PPH_RST_PORT;
         s_q.ctrl     <= PPH_RST_CTRL;
         s_q.flags    <= PPH_RST_FLAG;
         s_q.mask     <= PPH_RST_FLAG;
         s_q.ack_a    <= 1'b0;
         s_q.strobe_b <= 1'b1;
         s_q.rdata    <= 32'h0000_0000;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs.
   // ----------------------------------------------------------------------
   // Output enables follow the direction bits; data always driven.
   assign port_a_out = s_q.data_a;
   assign port_a_oe  = s_q.dir_a;
   assign port_b_out = s_q.data_b;
   assign port_b_oe  = s_q.dir_b;
   assign prdata     = s_q.rdata;

   // Outside handshake mode the line shows its programmed level.
   assign port_a_ack_out    = s_q.ctrl[PPH_CTRL_HS_A] ? s_q.ack_a
                                 : s_q.ctrl[PPH_CTRL_A_LVL];
   assign port_b_strobe_out = s_q.ctrl[PPH_CTRL_HS_B] ? s_q.strobe_b
                                 : s_q.ctrl[PPH_CTRL_B_LVL];

   // Level interrupt from any unmasked pending flag.
   assign irq   = |(s_q.flags & s_q.mask);
   assign irq_n = !irq;

   // ----------------------------------------------------------------------
   // Checks.
   // ----------------------------------------------------------------------
   chk_strobe_fall: assert property (
      @(posedge pclk) disable iff (!presetn)
      wr && paddr == PPH_OFF_DATA_B |=> !s_q.strobe_b)
      else $error("strobe did not fall after port B write");

   chk_strobe_hold: assert property (
      @(posedge pclk) disable iff (!presetn)
      !s_q.strobe_b && !ack_evt |=> !s_q.strobe_b)
      else $error("strobe rose without acknowledge");

   chk_strobe_rise: assert property (
      @(posedge pclk) disable iff (!presetn)
      ack_evt && !(wr && paddr == PPH_OFF_DATA_B)
      |=> s_q.strobe_b && s_q.flags[PPH_ST_ACK_B])
      else $error("acknowledge did not raise strobe and flag");

   chk_ready_flag: assert property (
      @(posedge pclk) disable iff (!presetn)
      rdy_evt |=> s_q.flags[PPH_ST_RDY_A])
      else $error("data-ready edge lost");

   chk_ack_high: assert property (
      @(posedge pclk) disable iff (!presetn)
      rdy_evt |=> s_q.ack_a)
      else $error("port A ack not raised");

   chk_ack_low: assert property (
      @(posedge pclk) disable iff (!presetn)
      rd && paddr == PPH_OFF_DATA_A && !rdy_evt |=> !s_q.ack_a)
      else $error("port A ack not dropped on read");

   chk_irq_line: assert property (
      @(posedge pclk) disable iff (!presetn)
      (irq_n == 1'b0) == ((s_q.flags & s_q.mask) != 2'h0))
      else $error("interrupt line disagrees with flags");

   chk_read_clear: assert property (
      @(posedge pclk) disable iff (!presetn)
      rd && paddr == PPH_OFF_DATA_A && !rdy_evt
      |=> !s_q.flags[PPH_ST_RDY_A])
      else $error("read did not clear port A flag");

   chk_reset_ports: assert property (
      @(posedge pclk)
      $rose(presetn) |-> s_q.dir_a == 8'h00 && s_q.dir_b == 8'h00
      && s_q.data_a == 8'h00 && s_q.data_b == 8'h00)
      else $error("ports not cleared by reset");

   chk_write_data: assert property (
      @(posedge pclk) disable iff (!presetn)
      wr && paddr == PPH_OFF_DATA_A |=> port_a_out == $past(pwdata[7:0]))
      else $error("write data not captured");

endmodule

// [common/pph_pkg.sv]
// Package of constants for the parallel port handshake block.
package pph_pkg;

   // ----------------------------------------------------------------------
   // Register map (byte offsets on the APB bus).
   // ----------------------------------------------------------------------
   localparam logic [7:0] PPH_OFF_DATA_A = 8'h00;
   localparam logic [7:0] PPH_OFF_DIR_A  = 8'h04;
   localparam logic [7:0] PPH_OFF_DATA_B = 8'h08;
   localparam logic [7:0] PPH_OFF_DIR_B  = 8'h0C;
   localparam logic [7:0] PPH_OFF_CTRL   = 8'h10;
   localparam logic [7:0] PPH_OFF_STAT   = 8'h14;
   localparam logic [7:0] PPH_OFF_MASK   = 8'h18;

   // ----------------------------------------------------------------------
   // Field positions.
   // ----------------------------------------------------------------------
   localparam int PPH_CTRL_HS_A    = 0;  // Port A read handshake enable.
   localparam int PPH_CTRL_HS_B    = 1;  // Port B write handshake enable.
   localparam int PPH_CTRL_A_LVL   = 2;  // Ack A level outside handshake.
   localparam int PPH_CTRL_B_LVL   = 3;  // Strobe B level outside handshake.
   localparam int PPH_CTRL_RDY_POS = 4;  // Data-ready active on rising edge.
   localparam int PPH_CTRL_ACK_POS = 5;  // Ack in active on rising edge.
   localparam int PPH_ST_RDY_A     = 0;  // Port A data-ready event.
   localparam int PPH_ST_ACK_B     = 1;  // Port B acknowledge event.

   // ----------------------------------------------------------------------
   // Reset values.
   // ----------------------------------------------------------------------
   localparam logic [7:0] PPH_RST_PORT = 8'h00;
   localparam logic [5:0] PPH_RST_CTRL = 6'h0C;
   localparam logic [1:0] PPH_RST_FLAG = 2'h0;

   // ----------------------------------------------------------------------
   // Cycle counts.
   // ----------------------------------------------------------------------
   // Edges are trusted once the edge history holds a real pin sample.
   localparam logic [1:0] PPH_EDGE_SETTLE = 2'h3;

endpackage

// [core/pph_sync.sv]
// Two-flop synchroniser bank for inputs that arrive from the pins.
`timescale 1ns/1ps
module pph_sync #(
   parameter int W = 1
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);

   logic [W-1:0] meta_q;

   // ----------------------------------------------------------------------
   // Synchroniser stages.
   // ----------------------------------------------------------------------
   // The first stage is read only by the second, to contain metastability.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q   <= '0;
         sync_out <= '0;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end

endmodule

// [core/pph_edge.sv]
// Selectable-polarity edge detector on a synchronised level.
`timescale 1ns/1ps
module pph_edge (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic level_in,
   input  wire logic rise_sel,
   output logic      edge_pulse
);

   import pph_pkg::*;

   typedef struct packed {
      logic       last;
      logic [1:0] age;
   } pph_edge_state_t;

   pph_edge_state_t e_q;
   pph_edge_state_t e_d;

   // ----------------------------------------------------------------------
   // History flop and pulse.
   // ----------------------------------------------------------------------
   // The synchroniser shows reset zeros for two cycles, so a pin that idles
   // high would fake a rising edge; the age counter waits for real samples.
   always_comb begin
      e_d      = e_q;
      e_d.last = level_in;
      if (e_q.age != PPH_EDGE_SETTLE) begin
         e_d.age = e_q.age + 2'h1;
      end
   end

   // History register.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         e_q.last <= 1'b0;
         e_q.age  <= 2'h0;
      end else begin
         e_q <= e_d;
      end
   end

   // One-cycle pulse on the selected transition.
   assign edge_pulse = (e_q.age == PPH_EDGE_SETTLE) &&
                       (rise_sel ? (level_in && !e_q.last)
                                 : (!level_in && e_q.last));

endmodule

// [tb/pph_periph.sv]
// Peripheral model that answers both port handshakes.
`timescale 1ns/1ps
module pph_periph (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       strobe_n,
   input  wire logic       ack_a,
   input  wire logic [7:0] b_lines,
   output logic      [7:0] a_lines,
   output logic      [7:0] b_idle,
   output logic      [7:0] got_b,
   output logic            rdy,
   output logic            ack_b
);
   int         dly    = 2;
   logic       hold   = 1'b0;
   logic [7:0] cnt    = 8'h00;
   logic [7:0] a_hold = 8'h00;
   logic       ack_a_q = 1'b0;
   // Released lines change every cycle, so stale data is never mistaken.
   assign a_lines = hold ? a_hold : cnt;
   assign b_idle  = ~cnt;
   // Data stays put until the acknowledge line drops after a read.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt     <= 8'h00;
         hold    <= 1'b0;
         ack_a_q <= 1'b0;
      end else begin
         cnt     <= cnt + 8'h01;
         ack_a_q <= ack_a;
         if (ack_a_q && !ack_a) begin
            hold <= 1'b0;
         end
      end
   end
   // Presents one byte and raises data-ready for two cycles.
   task send(input logic [7:0] d);
      @(posedge pclk);
      a_hold <= d;
      hold   <= 1'b1;
      rdy    <= 1'b1;
      repeat (2) @(posedge pclk);
      rdy <= 1'b0;
   endtask
   // Takes the byte a few cycles after the strobe falls, then acks.
   initial begin
      rdy   = 1'b0;
      ack_b = 1'b0;
      got_b = 8'h00;
      forever begin
         @(negedge strobe_n);
         repeat (dly) @(posedge pclk);
         got_b <= b_lines;
         ack_b <= 1'b1;
         wait (strobe_n === 1'b1);
         @(posedge pclk);
         ack_b <= 1'b0;
      end
   end
endmodule

// [tb/parallel_port_handshake_test.sv]
// Self-checking bench for the two handshaking ports.
`timescale 1ns/1ps
module parallel_port_handshake_test;
   import pph_pkg::*;
   typedef struct {string n; logic [32:0] v;} pph_note_t;
   logic        pclk = 1'b0, presetn = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready, pslverr, a_ack, strb, irq_n, irq, rdy, ack_b;
   logic [7:0]  a_in, a_out, a_oe, b_in, b_out, b_oe, a_far, b_far;
   logic [7:0]  got_b, d, m;
   int          seed = 5407, bad_count = 0, cmp_count = 0, cyc = 0;
   pph_note_t   notes[$];
   pph_note_t   nt;
   always #12.5 pclk = ~pclk;
   // Each pin shows the port's own drive where enabled, else the far side.
   assign a_in = (a_out & a_oe) | (a_far & ~a_oe);
   assign b_in = (b_out & b_oe) | (b_far & ~b_oe);
   pph_top u_pph_top (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .port_a_in(a_in), .port_a_out(a_out), .port_a_oe(a_oe),
      .port_b_in(b_in), .port_b_out(b_out), .port_b_oe(b_oe),
      .port_a_data_ready_in(rdy), .port_a_ack_out(a_ack),
      .port_b_ack_in(ack_b), .port_b_strobe_out(strb),
      .irq_n(irq_n), .irq(irq));
   pph_periph u_pph_periph (.pclk(pclk), .presetn(presetn),
      .strobe_n(strb), .ack_a(a_ack), .b_lines(b_in), .a_lines(a_far),
      .b_idle(b_far), .got_b(got_b), .rdy(rdy), .ack_b(ack_b));
   // ------------------------------------------------------------
   // Checking and bus tasks
   // ------------------------------------------------------------
   task cmp(input string n, input logic [32:0] e, input logic [32:0] g);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task stop_test;
      $display("checks %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Request is held until pready is seen high with penable.
   task apb(input logic w, input logic [7:0] a, input logic [31:0] v);
      @(posedge pclk);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= v;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] v);
      apb(1'b1, a, v);
   endtask
   task rd(input string n, input logic [7:0] a, input logic [32:0] e);
      notes.push_back('{n, e});
      apb(1'b0, a, 32'h0);
   endtask
   task settle(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask
   // Read results are matched against the oldest note.
   always @(posedge pclk) begin
      if (psel && penable && pready && !pwrite && notes.size() > 0) begin
         nt = notes.pop_front();
         cmp(nt.n, nt.v, {pslverr, prdata});
      end
   end
   // Ends a hung run; the whole sequence needs far fewer cycles.
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 6000) begin
         bad_count++;
         stop_test();
      end
   end
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      rd("dir_a", PPH_OFF_DIR_A, 33'h0);
      rd("dir_b", PPH_OFF_DIR_B, 33'h0);
      rd("ctrl", PPH_OFF_CTRL, 33'h0C);
      rd("stat", PPH_OFF_STAT, 33'h0);
      cmp("oe", 33'h0, 33'({a_oe, b_oe}));
      cmp("lines", 33'hE, 33'({strb, a_ack, irq_n, irq}));
      rd("unmapped", 8'h1C, 33'h100000000);
      wr(8'h1C, 32'hFF);
      rd("mask", PPH_OFF_MASK, 33'h0);
      for (int i = 0; i < 3; i++) begin
         d = 8'($random(seed));
         m = 8'($random(seed));
         wr(PPH_OFF_DATA_A, {24'h0, d});
         wr(PPH_OFF_DIR_A, {24'h0, m});
         wr(PPH_OFF_DIR_B, {24'h0, ~m});
         rd("dir_a", PPH_OFF_DIR_A, 33'(m));
         cmp("oe", 33'({m, ~m}), 33'({a_oe, b_oe}));
         cmp("a_out", 33'(d & m), 33'(a_out & a_oe));
      end
      wr(PPH_OFF_DIR_A, 32'h0);
      wr(PPH_OFF_DIR_B, 32'hFF);
      wr(PPH_OFF_MASK, 32'h3);
      wr(PPH_OFF_CTRL, 32'h3F);
      // Port B write handshake, prompt and slow peripheral.
      for (int k = 0; k < 2; k++) begin
         u_pph_periph.dly = k ? 12 : 2;
         d = 8'($random(seed));
         wr(PPH_OFF_DATA_B, {24'h0, d});
         settle(2);
         cmp("strobe", 33'h0, 33'(strb));
         settle(u_pph_periph.dly);
         cmp("strobe", 33'h0, 33'(strb));
         settle(8);
         cmp("strobe_irq", 33'h5, 33'({strb, irq_n, irq}));
         cmp("taken", 33'(d), 33'(got_b));
         rd("stat", PPH_OFF_STAT, 33'h2);
         rd("data_b", PPH_OFF_DATA_B, 33'(d));
         rd("stat", PPH_OFF_STAT, 33'h0);
      end
      // Port A read handshake, then again with the event masked.
      for (int k = 0; k < 2; k++) begin
         d = 8'($random(seed));
         wr(PPH_OFF_MASK, k ? 32'h0 : 32'h3);
         u_pph_periph.send(d);
         settle(6);
         cmp("ack_a", 33'h1, 33'(a_ack));
         cmp("irq", 33'(k ? 2'h2 : 2'h1), 33'({irq_n, irq}));
         rd("stat", PPH_OFF_STAT, 33'h1);
         if (k) begin
            wr(PPH_OFF_STAT, 32'h1);
            rd("stat", PPH_OFF_STAT, 33'h0);
         end
         rd("data_a", PPH_OFF_DATA_A, 33'(d));
         settle(1);
         cmp("ack_a", 33'h0, 33'(a_ack));
         rd("stat", PPH_OFF_STAT, 33'h0);
      end
      // Outside handshake mode the lines follow the programmed levels.
      wr(PPH_OFF_CTRL, 32'h08);
      wr(PPH_OFF_DATA_B, 32'h5A);
      settle(2);
      cmp("levels", 33'h2, 33'({strb, a_ack}));
      wr(PPH_OFF_CTRL, 32'h04);
      settle(2);
      cmp("levels", 33'h1, 33'({strb, a_ack}));
      settle(4);
      stop_test();
   end
endmodule
